// ==== logic/dofd_decoder.sv ====
// Purpose: Decodes opcode fields of the fixed-point DSP core into execute controls
// Assumes: Fetch presents a word with word_valid; field meaning lines are pre-split
// Notes: All outputs registered one cycle after word_valid
//
// Behaviour
// - Transfer bit copies addr reg 0 if true
// - Loop bit: 0 hardware loop, 1 repeat
// - Special control: stop, wait, swint, illegal
// - Bitfield op codes clr/set/tgl/move/tests/branches
// - Full-word mask forms take 16-bit mask
// - Byte forms: mask, byte select, branch field
// - End-loop is stack move to null register
// - Logical immediates run as bitfield ops
// - Transfer condition maps onto bits C2..C0
// - Codes 0000-0111 are the eight tests
// - Upper bits 10 always true
// - 1100-1111 higher, lower-same, norm, not-norm
// - E042 after short add means memory destination
// - Long add direction one means memory-to-register
// - Null-register source is address load only
// - Null-register destination is test-word read unless source is null or stack
// - Test-word on accumulator uses saturated 16
// - Pop register reads, bare pop adjusts pointer
// - Non-accumulator clear is move of zero
// - Opcode bit 2 selects conditional transfer
// - Stack register read pops, write pushes
// - Null-register read suppresses bus cycle
`timescale 1ns/10ps
`default_nettype none
module dofd_decoder (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic word_valid, // Fetch word present
  input wire logic [15:0] opcode, // Current instruction word
  input wire logic [15:0] next_word, // Following instruction word
  input wire logic [15:0] last_word, // Last word of a bitfield instr
  input wire logic is_loop, // Loop/repeat class
  input wire logic loop_type, // 0 loop, 1 repeat
  input wire logic is_special, // Special control class
  input wire logic [1:0] special_control_field, // Special control code
  input wire logic is_bitfield, // Bitfield/branch-on-bit class
  input wire logic [2:0] bitfield_op_field, // Bitfield op code
  input wire logic [1:0] logic_form, // Logical-immediate form
  input wire logic is_dalu, // Data-ALU region
  input wire logic [3:0] jump_condition_field, // Jump condition
  input wire logic is_short_add, // One-word add from short/stack mem
  input wire logic is_long_add, // Add with long absolute address
  input wire logic dir_bit, // Long add direction
  input wire logic is_move, // Move class
  input wire logic src_null, // Source is null_register_code
  input wire logic dst_null, // Destination is null_register_code
  input wire logic src_hws, // Source is hardware_loop_stack
  input wire logic dst_hws, // Destination is hardware_loop_stack
  input wire logic src_acc, // Source is a full accumulator
  input wire logic is_pop, // Pop alias
  input wire logic pop_has_reg, // Pop names a register
  input wire logic is_clr, // Clear alias
  input wire logic clr_full_acc, // Clear target is full accumulator
  input wire dofd_pkg::dofd_flags_t flags, // Status flags
  output dofd_pkg::dofd_ctl_t ctl, // Special control decode
  output dofd_pkg::dofd_bf_t bf, // Bitfield op decode
  output dofd_pkg::dofd_mask_t mask, // Mask and branch field
  output dofd_pkg::dofd_alias_t alias_o, // Alias decode
  output logic loop_hw, // Hardware loop
  output logic loop_rep, // Single-instruction repeat
  output logic tcc_sel, // Conditional transfer selected
  output logic cond_true, // Evaluated condition
  output logic cond_reserved, // Reserved condition code
  output logic agu_copy, // Copy addr reg 0 to addr reg 1
  output logic add_to_mem, // Two-word add to memory
  output logic add_mem_to_reg, // Long add memory-to-register
  output logic skip_next, // Next word consumed by pair
  output logic [15:0] abs_addr // Long add absolute address
);
  logic [3:0] cond_code;
  logic tcc_now;

  // Condition evaluation shared by both condition forms
  function automatic logic eval_cc(input logic [3:0] cc, input dofd_pkg::dofd_flags_t f);
    logic r;
    r = 1'b0;
    if (cc[3:2] == dofd_pkg::CC_TRUE_HI) begin
      r = 1'b1;
    end else begin
      case (cc)
        4'h0: r = ~f.c;
        4'h1: r = f.c;
        4'h2: r = ~f.z;
        4'h3: r = f.z;
        4'h4: r = ~(f.n ^ f.v);
        4'h5: r = f.n ^ f.v;
        4'h6: r = ~(f.z | (f.n ^ f.v));
        4'h7: r = f.z | (f.n ^ f.v);
        4'hc: r = ~(f.c | f.z);
        4'hd: r = f.c | f.z;
        4'he: r = f.u;
        4'hf: r = ~f.u;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction : eval_cc

  assign tcc_now = is_dalu && opcode[dofd_pkg::TCC_DIS_BIT];
  assign cond_code = tcc_now
    ? {1'b0, opcode[dofd_pkg::TCC_C2_BIT], opcode[dofd_pkg::TCC_CC_MSB:dofd_pkg::TCC_CC_LSB]}
    : jump_condition_field;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      loop_hw <= 1'b0;
      loop_rep <= 1'b0;
    end else begin
      loop_hw <= word_valid && is_loop && !loop_type;
      loop_rep <= word_valid && is_loop && loop_type;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctl <= '0;
    end else begin
      ctl <= '0;
      if (word_valid && is_special) begin
        case (special_control_field)
          dofd_pkg::SC_HALT: ctl.stop <= 1'b1;
          dofd_pkg::SC_WAIT: ctl.wait_lp <= 1'b1;
          dofd_pkg::SC_SWINT: ctl.swint <= 1'b1;
          default: ctl.illegal <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bf <= '0;
      mask <= '0;
    end else begin
      bf <= '0;
      mask <= '0;
      if (word_valid && is_bitfield) begin
        case (logic_form)
          dofd_pkg::LOG_AND: begin
            bf.clr <= 1'b1;
            mask.mask <= ~last_word;
          end
          dofd_pkg::LOG_OR_XOR: begin
            if (bitfield_op_field == dofd_pkg::BF_SET) bf.set <= 1'b1;
            else bf.tgl <= 1'b1;
            mask.mask <= last_word;
          end
          dofd_pkg::LOG_NOT: begin
            bf.tgl <= 1'b1;
            mask.mask <= dofd_pkg::MASK_ALL;
          end
          default: begin
            case (bitfield_op_field)
              dofd_pkg::BF_CLR: bf.clr <= 1'b1;
              dofd_pkg::BF_SET: bf.set <= 1'b1;
              dofd_pkg::BF_TGL: bf.tgl <= 1'b1;
              dofd_pkg::BF_MOVE: bf.move_imm <= 1'b1;
              dofd_pkg::BF_TSTL: bf.test_low <= 1'b1;
              dofd_pkg::BF_TSTH: bf.test_high <= 1'b1;
              dofd_pkg::BF_BRANCH_IF_BITS_CLEARED: bf.br_clr <= 1'b1;
              default: bf.br_set <= 1'b1;
            endcase
            if (bitfield_op_field[0] && bitfield_op_field[2]) begin
              mask.upper <= last_word[dofd_pkg::BYTE_SEL_BIT];
              mask.rel <= last_word[6:0];
              mask.has_branch <= 1'b1;
              mask.mask <= last_word[dofd_pkg::BYTE_SEL_BIT]
                ? {last_word[15:8], 8'h00} : {8'h00, last_word[15:8]};
            end else begin
              mask.mask <= last_word;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tcc_sel <= 1'b0;
      cond_true <= 1'b0;
      cond_reserved <= 1'b0;
      agu_copy <= 1'b0;
    end else begin
      tcc_sel <= word_valid && tcc_now;
      cond_true <= word_valid && eval_cc(cond_code, flags);
      cond_reserved <= word_valid && !tcc_now && cond_code[3:2] == dofd_pkg::CC_TRUE_HI
        && cond_code != dofd_pkg::CC_ALWAYS;
      agu_copy <= word_valid && tcc_now && opcode[dofd_pkg::TCC_Z_BIT]
        && eval_cc(cond_code, flags);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      add_to_mem <= 1'b0;
      add_mem_to_reg <= 1'b0;
      skip_next <= 1'b0;
      abs_addr <= dofd_pkg::ZERO_WORD;
    end else begin
      add_to_mem <= word_valid && is_short_add && next_word == dofd_pkg::ADD_MEM_DEST_WORD;
      add_mem_to_reg <= word_valid && is_long_add && dir_bit;
      skip_next <= word_valid && (is_long_add
        || (is_short_add && next_word == dofd_pkg::ADD_MEM_DEST_WORD));
      abs_addr <= (word_valid && is_long_add) ? next_word : dofd_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      alias_o <= '0;
    end else begin
      alias_o <= '0;
      if (word_valid) begin
        // end loop is stack to null
        alias_o.end_loop <= is_move && src_hws && dst_null;
        alias_o.lea <= (is_move && src_null) || (is_pop && !pop_has_reg);
        alias_o.test_word <= is_move && dst_null && !src_null && !src_hws;
        alias_o.test_word_op_sat16 <= is_move && dst_null && src_acc;
        alias_o.pop_reg <= is_pop && pop_has_reg;
        alias_o.pop_only <= is_pop && !pop_has_reg;
        alias_o.clr_imm0 <= is_clr && !clr_full_acc;
        alias_o.clr_sets_cc <= is_clr && clr_full_acc;
        alias_o.hws_pop <= is_move && src_hws;
        alias_o.hws_push <= is_move && dst_hws;
        alias_o.bus_suppress <= is_move && src_null;
        alias_o.mem_write_en <= is_move && !src_null && !dst_null && !is_pop;
      end
    end
  end

  property p_loop_excl;
    @(posedge mclk) disable iff (!rst_b) !(loop_hw && loop_rep);
  endproperty
  a_loop_excl: assert property (p_loop_excl) else $error("loop and repeat both set");

  property p_copy_needs_true;
    @(posedge mclk) disable iff (!rst_b) agu_copy |-> cond_true && tcc_sel;
  endproperty
  a_copy_needs_true: assert property (p_copy_needs_true) else $error("copy without true");

  property p_illegal_code;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_special && special_control_field == dofd_pkg::SC_ILLEGAL |=> ctl.illegal;
  endproperty
  a_illegal_code: assert property (p_illegal_code) else $error("illegal code missed");

  property p_e042_pair;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_short_add && next_word == dofd_pkg::ADD_MEM_DEST_WORD
        |=> add_to_mem && skip_next;
  endproperty
  a_e042_pair: assert property (p_e042_pair) else $error("memory add pair missed");

  property p_always_true;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && !tcc_now && jump_condition_field == dofd_pkg::CC_ALWAYS |=> cond_true;
  endproperty
  a_always_true: assert property (p_always_true) else $error("always code not true");

  property p_not_mask;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_bitfield && logic_form == dofd_pkg::LOG_NOT
        |=> bf.tgl && mask.mask == dofd_pkg::MASK_ALL;
  endproperty
  a_not_mask: assert property (p_not_mask) else $error("invert form wrong");

  property p_lea_no_write;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_move && src_null
        |=> alias_o.lea && !alias_o.mem_write_en && alias_o.bus_suppress;
  endproperty
  a_lea_no_write: assert property (p_lea_no_write) else $error("address load writes");

  property p_clr_cc;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_clr && !clr_full_acc |=> alias_o.clr_imm0 && !alias_o.clr_sets_cc;
  endproperty
  a_clr_cc: assert property (p_clr_cc) else $error("clear sets codes");

  property p_hws_pop;
    @(posedge mclk) disable iff (!rst_b)
      word_valid && is_move && src_hws |=> alias_o.hws_pop;
  endproperty
  a_hws_pop: assert property (p_hws_pop) else $error("stack read no pop");
endmodule : dofd_decoder
`default_nettype wire

// ==== logic/dofd_pkg.sv ====
// Purpose: Shared constants and carriers for the opcode field decoder
// Assumes: 16-bit instruction words, fields pre-extracted by fetch
// Notes: Field codes match the core's encoding map
package dofd_pkg;
  localparam logic [1:0] SC_HALT = 2'h0;
  localparam logic [1:0] SC_WAIT = 2'h1;
  localparam logic [1:0] SC_SWINT = 2'h2;
  localparam logic [1:0] SC_ILLEGAL = 2'h3;
  localparam logic [2:0] BF_CLR = 3'h0;
  localparam logic [2:0] BF_SET = 3'h1;
  localparam logic [2:0] BF_TGL = 3'h2;
  localparam logic [2:0] BF_MOVE = 3'h3;
  localparam logic [2:0] BF_TSTL = 3'h4;
  localparam logic [2:0] BF_BRANCH_IF_BITS_CLEARED = 3'h5;
  localparam logic [2:0] BF_TSTH = 3'h6;
  localparam logic [2:0] BF_BRANCH_IF_BITS_SET = 3'h7;
  localparam logic [15:0] ADD_MEM_DEST_WORD = 16'he042;
  localparam logic [15:0] MASK_ALL = 16'hffff;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [3:0] CC_ALWAYS = 4'h9;
  localparam logic [1:0] CC_TRUE_HI = 2'h2;
  localparam int BYTE_SEL_BIT = 7;
  localparam int TCC_DIS_BIT = 2;
  // Transfer word ends in 01CZ: C on bit 1, Z on bit 0, CC on bits 9..8
  localparam int TCC_C2_BIT = 1;
  localparam int TCC_Z_BIT = 0;
  localparam int TCC_CC_LSB = 8;
  localparam int TCC_CC_MSB = 9;
  localparam logic [1:0] TCC_TAG = 2'h1;
  // Logical-immediate forms mapped onto bitfield ops
  localparam logic [1:0] LOG_NONE = 2'h0;
  localparam logic [1:0] LOG_AND = 2'h1;
  localparam logic [1:0] LOG_OR_XOR = 2'h2;
  localparam logic [1:0] LOG_NOT = 2'h3;
  // Flag word: c z n v, normalized flag u
  typedef struct packed {
    logic c;
    logic z;
    logic n;
    logic v;
    logic u;
  } dofd_flags_t;
  typedef struct packed {
    logic stop;
    logic wait_lp;
    logic swint;
    logic illegal;
  } dofd_ctl_t;
  typedef struct packed {
    logic clr;
    logic set;
    logic tgl;
    logic move_imm;
    logic test_low;
    logic test_high;
    logic br_clr;
    logic br_set;
  } dofd_bf_t;
  typedef struct packed {
    logic [15:0] mask;
    logic upper;
    logic [6:0] rel;
    logic has_branch;
  } dofd_mask_t;
  typedef struct packed {
    logic lea;
    logic test_word;
    logic test_word_op_sat16;
    logic pop_reg;
    logic pop_only;
    logic end_loop;
    logic clr_imm0;
    logic clr_sets_cc;
    logic hws_pop;
    logic hws_push;
    logic bus_suppress;
    logic mem_write_en;
  } dofd_alias_t;
endpackage : dofd_pkg

// ==== test/dofd_decoder_tb.sv ====
// Purpose: Self-checking bench for the opcode field decoder
// Assumes: One-cycle registered answer per valid word
// Notes: All stimulus except rst_b goes through the fetch model tasks
`timescale 1ns/10ps
`default_nettype none
module dofd_decoder_tb;
  logic mclk = 1'b0;
  logic rst_b;
  int mismatches = 0;
  int n_checks = 0;
  logic word_valid, is_loop, loop_type, is_special, is_bitfield, is_dalu, is_short_add;
  logic is_long_add, dir_bit, is_move, src_null, dst_null, src_hws, dst_hws, src_acc;
  logic is_pop, pop_has_reg, is_clr, clr_full_acc;
  logic [15:0] opcode, next_word, last_word, abs_addr;
  logic [1:0] special_control_field, logic_form;
  logic [2:0] bitfield_op_field;
  logic [3:0] jump_condition_field;
  dofd_pkg::dofd_flags_t flags;
  dofd_pkg::dofd_ctl_t ctl;
  dofd_pkg::dofd_bf_t bf;
  dofd_pkg::dofd_mask_t mask;
  dofd_pkg::dofd_alias_t alias_o;
  logic loop_hw, loop_rep, tcc_sel, cond_true, cond_reserved, agu_copy, add_to_mem;
  logic add_mem_to_reg, skip_next;
  dofd_pkg::dofd_flags_t cur_fl = 5'h00;
  dofd_pkg::dofd_flags_t fl_pat [3] = '{5'h00, 5'h15, 5'h0a};
  logic [7:0] bf_exp [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h04, 8'h01};

  always #20 mclk = ~mclk;

  dofd_fetch_model fm (
    .word_valid, .opcode, .next_word, .last_word, .is_loop, .loop_type, .is_special,
    .special_control_field, .is_bitfield, .bitfield_op_field, .logic_form, .is_dalu,
    .jump_condition_field, .is_short_add, .is_long_add, .dir_bit, .is_move, .src_null,
    .dst_null, .src_hws, .dst_hws, .src_acc, .is_pop, .pop_has_reg, .is_clr,
    .clr_full_acc, .flags
  );

  dofd_decoder uut (
    .mclk, .rst_b, .word_valid, .opcode, .next_word, .last_word, .is_loop, .loop_type,
    .is_special, .special_control_field, .is_bitfield, .bitfield_op_field, .logic_form,
    .is_dalu, .jump_condition_field, .is_short_add, .is_long_add, .dir_bit, .is_move,
    .src_null, .dst_null, .src_hws, .dst_hws, .src_acc, .is_pop, .pop_has_reg, .is_clr,
    .clr_full_acc, .flags, .ctl, .bf, .mask, .alias_o, .loop_hw, .loop_rep, .tcc_sel,
    .cond_true, .cond_reserved, .agu_copy, .add_to_mem, .add_mem_to_reg, .skip_next,
    .abs_addr
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // One word in, answer sampled one edge later
  task automatic step(input string k, input logic [15:0] op, input logic [15:0] nw,
      input logic [15:0] lw, input logic [3:0] f, input logic [4:0] m);
    @(posedge mclk);
    fm.issue(k, op, nw, lw, f, m);
    fm.set_flags(cur_fl);
    @(posedge mclk);
    fm.idle();
    #1;
  endtask : step

  // Expected truth of a jump condition code
  function automatic logic cc_eval(input logic [3:0] cc, input dofd_pkg::dofd_flags_t fl);
    logic lt;
    logic [15:0] t;
    lt = fl.n ^ fl.v;
    t = {!fl.u, fl.u, fl.c | fl.z, !(fl.c | fl.z), 4'hf, fl.z | lt, !(fl.z | lt), lt, !lt,
        fl.z, !fl.z, fl.c, !fl.c};
    return t[cc];
  endfunction : cc_eval

  initial begin
    rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    chk({ctl, bf, alias_o, loop_hw, loop_rep, tcc_sel, agu_copy, skip_next}, 32'h0);
    done("reset");
    for (int i = 0; i < 2; i++) begin
      step("loop", 16'h0, 16'h0, 16'h0, 4'(i), 5'h0);
      chk({loop_hw, loop_rep}, i ? 2'b01 : 2'b10);
    end
    for (int i = 0; i < 4; i++) begin
      step("spec", 16'h0, 16'h0, 16'h0, 4'(i), 5'h0);
      chk(ctl, 4'h8 >> i);
    end
    done("loop and special");
    for (int i = 0; i < 8; i++) begin
      step("bf", 16'h0, 16'h0, 16'ha5c3, 4'(i), 5'h0);
      chk(bf, bf_exp[i]);
      chk({mask.mask, mask.has_branch}, (i[0] && i[2]) ? 17'h14a01 : 17'h14b86);
      if (i[0] && i[2])
        chk({mask.upper, mask.rel}, 8'hc3);
    end
    step("bf", 16'h0, 16'h0, 16'h3c11, 4'h7, 5'h0);
    chk(mask, {16'h003c, 1'b0, 7'h11, 1'b1});
    step("bf", 16'h0, 16'h0, 16'h00f0, 4'h0, 5'h1);
    chk({bf, mask.mask}, {8'h80, 16'hff0f});
    step("bf", 16'h0, 16'h0, 16'h00f0, 4'h1, 5'h2);
    chk({bf, mask.mask}, {8'h40, 16'h00f0});
    step("bf", 16'h0, 16'h0, 16'h00f0, 4'h2, 5'h2);
    chk({bf, mask.mask}, {8'h20, 16'h00f0});
    step("bf", 16'h0, 16'h0, 16'h00f0, 4'h2, 5'h3);
    chk({bf, mask.mask}, {8'h20, 16'hffff});
    done("bitfield");
    for (int p = 0; p < 3; p++) begin
      cur_fl = fl_pat[p];
      for (int c = 0; c < 16; c++) begin
        step("none", 16'h0, 16'h0, 16'h0, 4'(c), 5'h0);
        chk({cond_true, cond_reserved}, {cc_eval(4'(c), cur_fl), c inside {8, 10, 11}});
      end
    end
    cur_fl = 5'h08;
    step("dalu", 16'h6f05, 16'h0, 16'h0, 4'h0, 5'h0);
    chk({tcc_sel, cond_true, agu_copy}, 3'b111);
    cur_fl = 5'h00;
    step("dalu", 16'h6f05, 16'h0, 16'h0, 4'h0, 5'h0);
    chk({tcc_sel, cond_true, agu_copy}, 3'b100);
    cur_fl = 5'h04;
    step("dalu", 16'h6d06, 16'h0, 16'h0, 4'h0, 5'h0);
    chk({tcc_sel, cond_true, agu_copy}, 3'b110);
    step("dalu", 16'h6f01, 16'h0, 16'h0, 4'h0, 5'h0);
    chk(tcc_sel, 1'b0);
    done("conditions");
    step("sadd", 16'h0, 16'he042, 16'h0, 4'h0, 5'h0);
    chk({add_to_mem, skip_next}, 2'b11);
    step("sadd", 16'h0, 16'he043, 16'h0, 4'h0, 5'h0);
    chk({add_to_mem, skip_next}, 2'b00);
    step("ladd", 16'h0, 16'h1234, 16'h0, 4'h0, 5'h1);
    chk({add_mem_to_reg, abs_addr}, {1'b1, 16'h1234});
    step("ladd", 16'h0, 16'h4321, 16'h0, 4'h0, 5'h0);
    chk({add_mem_to_reg, abs_addr}, {1'b0, 16'h4321});
    done("add");
    step("move", 16'h0, 16'h0, 16'h0, 4'h0, 5'h10);
    chk({alias_o.lea, alias_o.mem_write_en, alias_o.bus_suppress}, 3'b101);
    step("move", 16'h0, 16'h0, 16'h0, 4'h0, 5'h08);
    chk({alias_o.test_word, alias_o.mem_write_en, alias_o.bus_suppress}, 3'b100);
    step("move", 16'h0, 16'h0, 16'h0, 4'h0, 5'h09);
    chk({alias_o.test_word, alias_o.test_word_op_sat16}, 2'b11);
    step("move", 16'h0, 16'h0, 16'h0, 4'h0, 5'h0c);
    chk({alias_o.end_loop, alias_o.hws_pop}, 2'b11);
    step("move", 16'h0, 16'h0, 16'h0, 4'h0, 5'h02);
    chk({alias_o.hws_push, alias_o.hws_pop, alias_o.end_loop}, 3'b100);
    for (int i = 0; i < 2; i++) begin
      step("pop", 16'h0, 16'h0, 16'h0, 4'h0, 5'(i));
      chk({alias_o.pop_reg, alias_o.pop_only}, i ? 2'b10 : 2'b01);
      step("clr", 16'h0, 16'h0, 16'h0, 4'h0, 5'(i));
      chk({alias_o.clr_imm0, alias_o.clr_sets_cc}, i ? 2'b01 : 2'b10);
    end
    @(posedge mclk);
    #1;
    chk({ctl, bf, alias_o, loop_hw, loop_rep, tcc_sel, agu_copy, skip_next}, 32'h0);
    done("aliases");
    give_verdict();
  end

  // Tests need a few hundred cycles at most
  initial begin
    repeat (4000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end
endmodule : dofd_decoder_tb
`default_nettype wire

// ==== test/dofd_fetch_model.sv ====
// Purpose: Fetch-stage stand-in presenting words and class bits to the decoder
// Assumes: Its tasks are called by the bench at a rising mclk edge
// Notes: Released word lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module dofd_fetch_model (
  output logic word_valid, // Word present
  output logic [15:0] opcode, // Word
  output logic [15:0] next_word, // Following word
  output logic [15:0] last_word, // Last word
  output logic is_loop, // Class
  output logic loop_type, // Field
  output logic is_special, // Class
  output logic [1:0] special_control_field, // Field
  output logic is_bitfield, // Class
  output logic [2:0] bitfield_op_field, // Field
  output logic [1:0] logic_form, // Field
  output logic is_dalu, // Class
  output logic [3:0] jump_condition_field, // Field
  output logic is_short_add, // Class
  output logic is_long_add, // Class
  output logic dir_bit, // Field
  output logic is_move, // Class
  output logic src_null, // Field
  output logic dst_null, // Field
  output logic src_hws, // Field
  output logic dst_hws, // Field
  output logic src_acc, // Field
  output logic is_pop, // Class
  output logic pop_has_reg, // Field
  output logic is_clr, // Class
  output logic clr_full_acc, // Field
  output dofd_pkg::dofd_flags_t flags // Status flags
);
  initial begin
    {word_valid, opcode, next_word, last_word, is_loop, loop_type, is_special} = '0;
    {special_control_field, is_bitfield, bitfield_op_field, logic_form, is_dalu} = '0;
    {jump_condition_field, is_short_add, is_long_add, dir_bit, is_move, flags} = '0;
    {src_null, dst_null, src_hws, dst_hws, src_acc, is_pop, pop_has_reg, is_clr} = '0;
    clr_full_acc = 1'b0;
  end

  task automatic issue(input string k, input logic [15:0] op, input logic [15:0] nw,
      input logic [15:0] lw, input logic [3:0] f, input logic [4:0] m);
    word_valid <= 1'b1;
    opcode <= op;
    next_word <= (k != "sadd" && nw == dofd_pkg::ADD_MEM_DEST_WORD) ? ~nw : nw;
    last_word <= lw;
    is_loop <= (k == "loop");
    is_special <= (k == "spec");
    is_bitfield <= (k == "bf");
    is_dalu <= (k == "dalu");
    is_short_add <= (k == "sadd");
    is_long_add <= (k == "ladd");
    is_move <= (k == "move");
    is_pop <= (k == "pop");
    is_clr <= (k == "clr");
    loop_type <= f[0];
    {dir_bit, pop_has_reg, clr_full_acc, src_acc} <= {4{m[0]}};
    special_control_field <= f[1:0];
    bitfield_op_field <= f[2:0];
    jump_condition_field <= f;
    logic_form <= m[1:0];
    {src_null, dst_null} <= m[4:3];
    {src_hws, dst_hws} <= (k == "move") ? m[2:1] : 2'b00;
  endtask : issue

  task automatic idle();
    word_valid <= 1'b0;
    opcode <= ~opcode;
    next_word <= ~next_word;
    last_word <= ~last_word;
  endtask : idle

  task automatic set_flags(input dofd_pkg::dofd_flags_t fl);
    flags <= fl;
  endtask : set_flags
endmodule : dofd_fetch_model
`default_nettype wire
